// >>> rx_status_pkg.sv
// Purpose: shared constants for the receive status word and receiver control
// Assumes: APB register map, 32-bit data, one aligned word per register
// Notes:   byte thresholds follow Ethernet frame sizes with FCS included
package rx_status_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STAT_OFFSET   = 12'h004;
  localparam logic [11:0] LAST_OFFSET   = 12'h008;
  localparam logic [11:0] COUNT_OFFSET  = 12'h00C;
  // control register fields (mac_control_reg)
  localparam int RX_ENABLE_POS  = 0;
  localparam int MODE_10_POS    = 1;
  localparam int PASS_BAD_POS   = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status register fields
  localparam int RX_ERR_POS     = 0;
  localparam int HALTED_POS     = 1;
  localparam int BUSY_POS       = 2;
  // status word field positions
  localparam int SW_FILTER_FAIL = 30;
  localparam int SW_LEN_LSB     = 16;
  localparam int SW_ERR_SUM     = 15;
  localparam int SW_BROADCAST   = 13;
  localparam int SW_LEN_ERR     = 12;
  localparam int SW_RUNT        = 11;
  localparam int SW_MULTICAST   = 10;
  localparam int SW_TOO_LONG    = 7;
  localparam int SW_LATE_COL    = 6;
  localparam int SW_FRAME_TYPE  = 5;
  localparam int SW_WATCHDOG    = 4;
  localparam int SW_MII_ERR     = 3;
  localparam int SW_DRIBBLE     = 2;
  localparam int SW_CRC_ERR     = 1;
  // byte count thresholds
  localparam int RUNT_BYTES     = 64;
  localparam int MAX_BYTES      = 1518;
  localparam int TYPE_LIMIT     = 1500;
  localparam int HEADER_BYTES   = 14;
  localparam int HDR_FCS_BYTES  = 18;
  localparam int LENTYPE_HI_IDX = 12;
  localparam int LENTYPE_LO_IDX = 13;
  localparam int WDOG_DEFAULT   = 2048;
  localparam int WDOG_MIN       = 2048;
  localparam int WDOG_MAX       = 2560;
  localparam int DRIBBLE_MII    = 4;
  localparam int DRIBBLE_10M    = 3;
endpackage

// >>> frame_byte_counter.sv
// Purpose: counts received bytes, catches the length/type field, watchdog
// Assumes: byteValid marks one byte per cycle inside a frame
// Notes:   the count saturates instead of wrapping
`timescale 1ns/1ps
`default_nettype none
module frame_byte_counter
  import rx_status_pkg::*;
#(
  parameter int LEN_W      = 14,
  parameter int WDOG_BYTES = WDOG_DEFAULT
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic             byteValid,
  input  wire logic [7:0]       byteData,
  output logic      [LEN_W-1:0] count,
  output logic      [15:0]      lenType,
  output logic                  wdogHit
);
  logic saturated;
  assign saturated = &count;
  assign wdogHit   = count >= LEN_W'(WDOG_BYTES);

  // byte count and length/type capture, most significant byte first
  always_ff @(posedge clock) begin
    if (!rst_n || start) begin
      count   <= '0;
      lenType <= 16'h0000;
    end else if (byteValid) begin
      if (!saturated) count <= count + LEN_W'(1);
      if (count == LEN_W'(LENTYPE_HI_IDX)) lenType[15:8] <= byteData;
      if (count == LEN_W'(LENTYPE_LO_IDX)) lenType[7:0]  <= byteData;
    end
  end
endmodule
`default_nettype wire

// >>> status_word_pack.sv
// Purpose: assembles one 32-bit receive status word from frame flags
// Assumes: all inputs stable when the word is sampled
// Notes:   reserved bits are tied to zero here
`timescale 1ns/1ps
`default_nettype none
module status_word_pack
  import rx_status_pkg::*;
#(
  parameter int LEN_W = 14
) (
  input  wire logic [LEN_W-1:0] length,
  input  wire logic             filterFail,
  input  wire logic             broadcast,
  input  wire logic             lenMismatch,
  input  wire logic             runt,
  input  wire logic             multicast,
  input  wire logic             tooLong,
  input  wire logic             lateCol,
  input  wire logic             frameType,
  input  wire logic             watchdog,
  input  wire logic             miiErr,
  input  wire logic             dribble,
  input  wire logic             crcErr,
  output logic      [31:0]      word
);
  logic errSum;
  // error_summary_flag
  assign errSum = runt | tooLong | lateCol | crcErr;
  // reserved bits 31, 14, 9:8 and 0 stay zero
  always_comb begin
    word = 32'h0000_0000;
    word[SW_FILTER_FAIL] = filterFail;
    word[SW_LEN_LSB +: LEN_W] = length;
    word[SW_ERR_SUM]     = errSum;
    word[SW_BROADCAST]   = broadcast;
    word[SW_LEN_ERR]     = lenMismatch;
    word[SW_RUNT]        = runt;
    word[SW_MULTICAST]   = multicast;
    word[SW_TOO_LONG]    = tooLong;
    word[SW_LATE_COL]    = lateCol;
    word[SW_FRAME_TYPE]  = frameType;
    word[SW_WATCHDOG]    = watchdog;
    word[SW_MII_ERR]     = miiErr;
    word[SW_DRIBBLE]     = dribble;
    word[SW_CRC_ERR]     = crcErr;
  end
endmodule
`default_nettype wire

// >>> rx_status_ctrl.sv
// Purpose: per-frame receive status word, receiver stop/start, error flag
// Assumes: frameEnd follows the last byteValid; dataDone marks the data
//          FIFO holding all data of the ended frame
// Notes:   APB slave answers with pready in the first access cycle
`timescale 1ns/1ps
`default_nettype none
module rx_status_ctrl
  import rx_status_pkg::*;
#(
  parameter int LEN_W      = 14,
  parameter int WDOG_BYTES = WDOG_DEFAULT
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // receive events from the mac_interface_layer
  input  wire logic        frameStart,
  input  wire logic        byteValid,
  input  wire logic [7:0]  byteData,
  input  wire logic        frameEnd,
  input  wire logic        fcsBad,
  input  wire logic        rxEr,
  input  wire logic        lateCollision,
  input  wire logic [2:0]  dribbleBits,
  input  wire logic        dstBroadcast,
  input  wire logic        dstMulticast,
  input  wire logic        filterFail,
  input  wire logic        dataDone,
  // FIFO condition inputs
  input  wire logic        statusFifoFull,
  input  wire logic        dataUnderrun,
  input  wire logic        statusUnderrun,
  // outputs
  output logic      [31:0] statusWord,
  output logic             statusPush,
  output logic             frameDrop,
  output logic             receiveEnable,
  output logic             receiverHaltedPulse,
  output logic             receiverErrorFlag
);
  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DRAIN, ST_STOPPED} state_t;

  initial begin
    if (LEN_W < 12 || LEN_W > 14) $error("LEN_W must be 12..14");
    if (WDOG_BYTES < WDOG_MIN || WDOG_BYTES > WDOG_MAX)
      $error("WDOG_BYTES out of range");
  end

  // register address decode, used by read and write paths
  function automatic logic [2:0] decode(input logic [11:0] a);
    unique case (a)
      CTRL_OFFSET:  decode = 3'h1;
      STAT_OFFSET:  decode = 3'h2;
      LAST_OFFSET:  decode = 3'h3;
      COUNT_OFFSET: decode = 3'h4;
      default:      decode = 3'h0;
    endcase
  endfunction

  state_t            state_reg, state_next;
  logic [31:0]       ctrl_reg;
  logic [31:0]       pending_reg;
  logic              drop_reg;
  logic              rxErSeen_reg;
  logic [31:0]       frameCount_reg;
  logic [LEN_W-1:0]  count;
  logic [15:0]       lenType;
  logic              wdogHit;
  logic [31:0]       packedWord;
  logic              acceptStart;

  // byte counting, length/type capture and watchdog
  frame_byte_counter #(
    .LEN_W      (LEN_W),
    .WDOG_BYTES (WDOG_BYTES)
  ) u_counter (
    .clock     (clock),
    .rst_n     (rst_n),
    .start     (acceptStart),
    .byteValid (byteValid && state_reg == ST_FRAME),
    .byteData  (byteData),
    .count     (count),
    .lenType   (lenType),
    .wdogHit   (wdogHit)
  );

  // frame classification at end of frame
  logic             isRunt;
  logic             isTooLong;
  logic             hasHeader;
  logic             isTypeFrame;
  logic [LEN_W-1:0] payload;
  logic             lenMismatch;
  logic             dribbleOk;
  logic             dribble;
  logic             crcErr;
  logic             miiErr;
  logic             passBad;
  logic             mode10;
  assign passBad     = ctrl_reg[PASS_BAD_POS];
  assign mode10      = ctrl_reg[MODE_10_POS];
  assign isRunt      = count < LEN_W'(RUNT_BYTES);
  assign isTooLong   = count > LEN_W'(MAX_BYTES);
  assign hasHeader   = count >= LEN_W'(HEADER_BYTES);
  assign isTypeFrame = hasHeader && lenType > 16'(TYPE_LIMIT);
  assign payload     = hasHeader ? count - LEN_W'(HDR_FCS_BYTES) : '0;
  // short payloads are padded, so only a field larger than the data or
  // a non-runt frame of another size counts as a mismatch
  assign lenMismatch = hasHeader && !isTypeFrame &&
                       (16'(payload) < lenType ||
                        (!isRunt && 16'(payload) != lenType));
  assign dribbleOk   = mode10 ? dribbleBits >= 3'(DRIBBLE_10M)
                              : dribbleBits == 3'(DRIBBLE_MII);
  assign dribble     = dribbleOk && !lateCollision;
  assign miiErr      = rxErSeen_reg || rxEr;
  assign crcErr      = fcsBad || miiErr;

  // status word assembly
  status_word_pack #(
    .LEN_W (LEN_W)
  ) u_pack (
    .length      (count),
    .filterFail  (filterFail),
    .broadcast   (dstBroadcast),
    .lenMismatch (lenMismatch),
    .runt        (isRunt),
    .multicast   (dstMulticast),
    .tooLong     (isTooLong),
    .lateCol     (lateCollision),
    .frameType   (isTypeFrame),
    .watchdog    (wdogHit),
    .miiErr      (miiErr),
    .dribble     (dribble),
    .crcErr      (crcErr),
    .word        (packedWord)
  );

  // receiver sequencing
  logic rxEnabled;
  logic pushNow;
  logic dropNow;
  logic haltNow;
  assign rxEnabled   = ctrl_reg[RX_ENABLE_POS];
  assign acceptStart = state_reg == ST_IDLE && rxEnabled && frameStart;
  assign pushNow     = state_reg == ST_DRAIN && dataDone && !drop_reg;
  assign dropNow     = state_reg == ST_DRAIN && dataDone && drop_reg;
  assign haltNow     = state_reg == ST_IDLE && !rxEnabled;

  // next state: a frame in progress always finishes before halting
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (haltNow) state_next = ST_STOPPED;
        else if (acceptStart) state_next = ST_FRAME;
      end
      ST_FRAME: begin
        if (frameEnd) state_next = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (dataDone) state_next = ST_IDLE;
      end
      ST_STOPPED: begin
        if (rxEnabled) state_next = ST_IDLE;
      end
    endcase
  end

  // state and per-frame bookkeeping
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      rxErSeen_reg <= 1'b0;
      pending_reg  <= 32'h0000_0000;
      drop_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (acceptStart) rxErSeen_reg <= 1'b0;
      else if (state_reg == ST_FRAME && rxEr) rxErSeen_reg <= 1'b1;
      if (state_reg == ST_FRAME && frameEnd) begin
        pending_reg <= packedWord;
        drop_reg    <= isRunt && !passBad;
      end
    end
  end

  // output strobes and the word handed to the status FIFO
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      statusWord          <= 32'h0000_0000;
      statusPush          <= 1'b0;
      frameDrop           <= 1'b0;
      receiverHaltedPulse <= 1'b0;
      receiveEnable       <= 1'b0;
    end else begin
      statusPush          <= pushNow;
      frameDrop           <= dropNow;
      receiverHaltedPulse <= haltNow;
      receiveEnable       <= rxEnabled && state_next != ST_STOPPED;
      if (pushNow) statusWord <= pending_reg;
    end
  end

  // APB decode and data selection
  logic        setupPhase;
  logic        writeTaken;
  logic [2:0]  setupSel;
  logic [2:0]  accessSel;
  logic [31:0] statReg;
  logic [31:0] readMux;
  logic        errSet;
  logic        errClr;
  logic        errNext;
  assign setupPhase = psel && !penable;
  assign writeTaken = psel && penable && pready && pwrite;
  assign setupSel   = decode(paddr);
  assign accessSel  = decode(paddr);
  assign statReg    = {29'h0, state_reg == ST_FRAME || state_reg == ST_DRAIN,
                       state_reg == ST_STOPPED, receiverErrorFlag};
  assign readMux    = setupSel == 3'h1 ? ctrl_reg :
                      setupSel == 3'h2 ? statReg :
                      setupSel == 3'h3 ? statusWord :
                      setupSel == 3'h4 ? frameCount_reg : 32'h0000_0000;
  // receiver_error_flag: a new event wins over a same-cycle clear
  assign errSet  = dataUnderrun || statusUnderrun ||
                   (pushNow && statusFifoFull);
  assign errClr  = writeTaken && accessSel == 3'h2 && pwdata[RX_ERR_POS];
  assign errNext = errSet || (receiverErrorFlag && !errClr);

  // APB answer: ready one cycle after setup, error for unmapped offsets
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && setupSel == 3'h0;
      prdata  <= setupPhase && !pwrite ? readMux : 32'h0000_0000;
    end
  end

  // software registers and counters
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg          <= CTRL_RESET;
      receiverErrorFlag <= 1'b0;
      frameCount_reg    <= 32'h0000_0000;
    end else begin
      receiverErrorFlag <= errNext;
      if (pushNow) frameCount_reg <= frameCount_reg + 32'h0000_0001;
      if (writeTaken && accessSel == 3'h1) ctrl_reg <= pwdata;
    end
  end
endmodule
`default_nettype wire

// >>> rx_status_ctrl_monitor.sv
// Purpose: assertions on the receive status word and receiver control
// Assumes: sees only top ports, one clock domain
// Notes:   bound to every rx_status_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module rx_status_ctrl_monitor #(
  parameter int LEN_W      = 14,
  parameter int WDOG_BYTES = 2048
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        dataDone,
  input wire logic        dataUnderrun,
  input wire logic        statusUnderrun,
  input wire logic [31:0] statusWord,
  input wire logic        statusPush,
  input wire logic        receiverHaltedPulse,
  input wire logic        receiverErrorFlag
);
  wire logic [LEN_W-1:0] len;
  // length field of the pushed word
  assign len = statusWord[16 +: LEN_W];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // single-cycle pulse shapes
  sequence s_push; statusPush ##1 !statusPush; endsequence
  sequence s_halt; receiverHaltedPulse ##1 !receiverHaltedPulse; endsequence
  a_reserved_zero: assert property (
    statusPush |-> (statusWord & 32'h8000_4301) == 32'h0000_0000)
    else $error("reserved status bits set");
  a_err_summary: assert property (
    statusPush |-> statusWord[15] == (statusWord[11] | statusWord[7]
    | statusWord[6] | statusWord[1])) else $error("summary flag wrong");
  a_runt_flag: assert property (
    statusPush && len < 64 |-> statusWord[11]) else $error("runt missed");
  a_long_flag: assert property (
    statusPush && len > 1518 |-> statusWord[7]) else $error("long missed");
  a_type_short: assert property (
    statusPush && len < 14 |-> !statusWord[5]) else $error("type on runt");
  a_wdog_flag: assert property (
    statusPush && len >= WDOG_BYTES |-> statusWord[4])
    else $error("watchdog missed");
  a_dribble_late: assert property (
    statusPush |-> !(statusWord[2] && statusWord[6]))
    else $error("dribble with late collision");
  a_push_order: assert property (
    statusPush |-> $past(dataDone)) else $error("push before data done");
  a_push_single: assert property (
    statusPush |-> s_push) else $error("push longer than one cycle");
  a_halt_single: assert property (
    receiverHaltedPulse |-> s_halt) else $error("halt pulse too long");
  a_err_raise: assert property (
    dataUnderrun || statusUnderrun |=> receiverErrorFlag)
    else $error("error flag not raised");
endmodule
bind rx_status_ctrl rx_status_ctrl_monitor #(.LEN_W(LEN_W),
  .WDOG_BYTES(WDOG_BYTES)) mon (.clock, .rst_n, .dataDone, .dataUnderrun,
  .statusUnderrun, .statusWord, .statusPush, .receiverHaltedPulse,
  .receiverErrorFlag);
`default_nettype wire

// >>> rx_host_model.sv
// Purpose: host side that pops each queued status word
// Assumes: host drains the status queue at once
// Notes:   keeps the last word and a running count
`timescale 1ns/1ps
`default_nettype none
module rx_host_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        statusPush,
  input  wire logic [31:0] statusWord,
  output logic      [15:0] wordCount,
  output logic      [31:0] lastWord
);
  // read each word so the host can judge errors itself
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wordCount <= 16'h0000;
      lastWord  <= 32'h0000_0000;
    end else if (statusPush) begin
      wordCount <= wordCount + 16'h0001;
      lastWord  <= statusWord;
    end
  end
endmodule
`default_nettype wire

// >>> rx_status_ctrl_tb_top.sv
// Purpose: self-checking bench for rx_status_ctrl
// Assumes: 40 MHz clock, APB answers in the first access cycle
// Notes:   frame rows hold stimulus beside the expected status word
`timescale 1ns/1ps
`default_nettype none
module rx_status_ctrl_tb_top;
  import rx_status_pkg::*;
  typedef struct {int nb; logic [15:0] lt; logic [8:0] f;
                  logic [31:0] exp;} row_t;
  logic        clock, rst_n, psel, penable, pwrite, frameStart, byteValid;
  logic        frameEnd, fcsBad, rxEr, lateCollision, dstBroadcast;
  logic        dstMulticast, filterFail, dataDone, statusFifoFull;
  logic        dataUnderrun, statusUnderrun, pready, pslverr, statusPush;
  logic        frameDrop, receiveEnable, receiverHaltedPulse, e;
  logic        receiverErrorFlag;
  logic [1:0]  got;
  logic [2:0]  dribbleBits;
  logic [7:0]  byteData;
  logic [11:0] paddr;
  logic [15:0] wordCount;
  logic [31:0] pwdata, prdata, statusWord, lastWord, r, w;
  int          n_mismatch, comparisons, cycles, i;
  // flags: dribble[8:6] bcast mcast fcs late filter rxEr
  row_t        rows [6] = '{
    '{64,   16'h0800, 9'h020, 32'h0040_2020},
    '{20,   16'h0002, 9'h018, 32'h0014_8C02},
    '{10,   16'h0000, 9'h000, 32'h000A_8800},
    '{1519, 16'h0010, 9'h106, 32'h45EF_90C0},
    '{100,  16'h0052, 9'h101, 32'h0064_800E},
    '{2048, 16'h0800, 9'h000, 32'h0800_80B0}};

  rx_status_ctrl dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .frameStart, .byteValid,
    .byteData, .frameEnd, .fcsBad, .rxEr, .lateCollision, .dribbleBits,
    .dstBroadcast, .dstMulticast, .filterFail, .dataDone, .statusFifoFull,
    .dataUnderrun, .statusUnderrun, .statusWord, .statusPush, .frameDrop,
    .receiveEnable, .receiverHaltedPulse, .receiverErrorFlag);
  rx_host_model host (.clock, .rst_n, .statusPush, .statusWord,
    .wordCount, .lastWord);

  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic frame(input int nb, input logic [15:0] lt,
                       input logic [8:0] f, output logic [1:0] g,
                       output logic [31:0] wd);
    int k;
    @(posedge clock);
    frameStart <= 1'b1;
    {dribbleBits, dstBroadcast, dstMulticast, fcsBad, lateCollision,
     filterFail, rxEr} <= f;
    for (k = 0; k < nb; k++) begin
      @(posedge clock);
      {frameStart, byteValid} <= 2'b01;
      byteData <= k == 12 ? lt[15:8] : k == 13 ? lt[7:0] : 8'(k);
    end
    @(posedge clock);
    {frameStart, byteValid, frameEnd} <= 3'b001;
    @(posedge clock);
    {frameEnd, dataDone} <= 2'b01;
    @(posedge clock);
    {dataDone, dribbleBits, dstBroadcast, dstMulticast, fcsBad,
     lateCollision, filterFail, rxEr} <= '0;
    for (k = 0; k < 8 && statusPush !== 1'b1 && frameDrop !== 1'b1; k++)
      @(posedge clock);
    g = {statusPush === 1'b1, frameDrop === 1'b1};
    wd = statusWord;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, frameStart, byteValid, byteData,
     frameEnd, fcsBad, rxEr, lateCollision, dribbleBits, dstBroadcast,
     dstMulticast, filterFail, dataDone, statusFifoFull, dataUnderrun,
     statusUnderrun, rst_n} = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, CTRL_OFFSET, 32'h0, r, e);
    chk(r, CTRL_RESET);
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h8000_0000);
    apb(1'b1, CTRL_OFFSET, 32'h0001_0001, r, e);
    apb(1'b0, CTRL_OFFSET, 32'h0, r, e);
    chk(r, 32'h0001_0001);
    foreach (rows[k]) begin
      frame(rows[k].nb, rows[k].lt, rows[k].f, got, w);
      chk({30'h0, got}, 32'h2);
      chk(rows[k].nb < 14 ? w & ~32'h1000 : w, rows[k].exp);
      $display("frame row %0d done", k);
    end
    apb(1'b0, LAST_OFFSET, 32'h0, r, e);
    chk(r, rows[5].exp);
    apb(1'b0, COUNT_OFFSET, 32'h0, r, e);
    chk(r, 32'h6);
    chk({wordCount, lastWord[15:0]}, {16'h6, rows[5].exp[15:0]});
    apb(1'b1, CTRL_OFFSET, 32'h1, r, e);
    frame(20, 16'h0002, 9'h000, got, w);
    chk({30'h0, got}, 32'h1);
    $display("runt drop done");
    for (int c = 0; c < 3; c++) begin
      @(posedge clock);
      {dataUnderrun, statusUnderrun, statusFifoFull} <= 3'b100 >> c;
      @(posedge clock);
      {dataUnderrun, statusUnderrun} <= 2'b00;
      frame(64, 16'h0800, 9'h000, got, w);
      statusFifoFull <= 1'b0;
      chk({30'h0, got}, 32'h2);
      @(posedge clock);
      chk({31'h0, receiverErrorFlag}, 32'h1);
      apb(1'b1, STAT_OFFSET, 32'h1, r, e);
      apb(1'b0, STAT_OFFSET, 32'h0, r, e);
      chk({31'h0, r[0]}, 32'h0);
      $display("error cause %0d done", c);
    end
    // host soft reset after the underruns, then re-enable the receiver
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, COUNT_OFFSET, 32'h0, r, e);
    chk({r[30:0], receiverErrorFlag}, 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h1, r, e);
    $display("soft reset done");
    apb(1'b1, CTRL_OFFSET, 32'h0, r, e);
    for (i = 0; i < 20 && receiverHaltedPulse !== 1'b1; i++)
      @(posedge clock);
    chk({receiverHaltedPulse, receiveEnable}, 32'h2);
    frame(64, 16'h0800, 9'h000, got, w);
    chk({30'h0, got}, 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h1, r, e);
    repeat (2) @(posedge clock);
    chk({31'h0, receiveEnable}, 32'h1);
    frame(64, 16'h0800, 9'h000, got, w);
    chk({30'h0, got}, 32'h2);
    $display("halt and restart done");
    finish_test;
  end
endmodule
`default_nettype wire
